// [verilog/nvmopr_consts.svh]
// Offsets, field positions, reset values and limits of the option block
// Assumes byte addresses on a 32-bit AXI4-Lite register bus
`ifndef NVMOPR_CONSTS_SVH
`define NVMOPR_CONSTS_SVH
`define NVMOPR_OFS_OPTION     8'h00
`define NVMOPR_OFS_CONFIG     8'h04
`define NVMOPR_OFS_PROTECTION 8'h08
`define NVMOPR_OFS_STATUS     8'h0c
`define NVMOPR_BIT_KEY_EN     7
`define NVMOPR_BIT_REDIR_DIS  6
`define NVMOPR_BIT_SECT_MODE  5
`define NVMOPR_BIT_PAGE_SEL   6
`define NVMOPR_BIT_KEY_ACC    5
`define NVMOPR_BIT_VIOL       5
`define NVMOPR_OPT_MASK       8'he3
`define NVMOPR_SEC_OPEN       2'h2
`define NVMOPR_RST_OPTION     8'h00
`define NVMOPR_RST_PROT       8'h00
`define NVMOPR_FPS_NONE       6'h3f
`define NVMOPR_FPS_ALL        6'h18
`define NVMOPR_EPS_NONE       2'h3
`define NVMOPR_FLASH_TOP      17'h10000
`define NVMOPR_FLASH_STEP     17'h00600
`define NVMOPR_EE_TOP         16'h1800
`define NVMOPR_EE_STEP        16'h0010
`define NVMOPR_KEY_BASE       16'hffb0
`define NVMOPR_KEY_LAST       3'h7
`define NVMOPR_RESP_OKAY      2'h0
`define NVMOPR_RESP_SLVERR    2'h2
`endif

// [verilog/nvmopr_pkg.sv]
// Types of the option and protection block
// Assumes nothing beyond the constants header
package nvmopr_pkg;
  typedef enum logic [1:0] {
    NVMOPR_LOAD = 2'b00,
    NVMOPR_RUN  = 2'b01
  } nvmopr_fsm_t;

  typedef struct packed {
    nvmopr_fsm_t fsm;
    logic [7:0]  opt;
    logic        page_sel;
    logic        key_acc;
    logic [7:0]  prot;
    logic        viol;
    logic [2:0]  key_cnt;
    logic        key_bad;
    logic        cmd_go;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } nvmopr_state_t;
endpackage

// [verilog/nvmopr_top.sv]
// Option, configuration and protection registers of the NVM controller
// Assumes single clock; command and source inputs come from same-clock logic
module nvmopr_top
  import nvmopr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        DEBUG_ACCESS,
  input  wire logic [7:0]  NV_OPTION,
  input  wire logic [7:0]  NV_PROTECTION,
  input  wire logic [63:0] STORED_KEY,
  input  wire logic        BLANK_OK,
  input  wire logic        UNSECURE_SRC,
  input  wire logic        CMD_VALID,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_DATA,
  input  wire logic        CMD_EEPROM,
  input  wire logic        CMD_MASS,
  input  wire logic        CMD_DEBUG,
  output logic             SECURE,
  output logic             ACCESS_BLOCK,
  output logic             VECTOR_REDIRECT_DISABLE,
  output logic             EEPROM_SECTOR_MODE,
  output logic             EEPROM_PAGE_SELECT,
  output logic             KEY_WRITE_ACCESS,
  output logic             PROT_VIOLATION,
  output logic             CMD_GO
);
`include "nvmopr_consts.svh"

  nvmopr_state_t q;
  nvmopr_state_t d;
  logic          secure;
  logic          wr_fire;
  logic          wr_prot;
  logic          wr_dbg;
  logic          key_hit;
  logic          key_take;
  logic          key_fail;
  logic          viol_set;
  logic          viol_clr;
  logic          prot_any;
  logic [16:0]   flash_start;
  logic [15:0]   ee_size;
  logic          hit_prot;
  logic [7:0]    rd_val;
  logic          rd_ok;

  assign secure        = q.opt[1:0] != `NVMOPR_SEC_OPEN;
  assign prot_any      = q.prot != 8'hff;
  assign S_AXI_AWREADY = ~q.aw_full & ~q.bvalid;
  assign S_AXI_WREADY  = ~q.w_full & ~q.bvalid;
  assign S_AXI_ARREADY = ~q.rvalid;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RRESP   = q.rresp;
  assign S_AXI_RDATA   = {24'h000000, q.rdata};
  assign SECURE        = secure;
  assign ACCESS_BLOCK  = secure & UNSECURE_SRC;
  assign VECTOR_REDIRECT_DISABLE = q.opt[`NVMOPR_BIT_REDIR_DIS];
  assign EEPROM_SECTOR_MODE = q.opt[`NVMOPR_BIT_SECT_MODE];
  assign EEPROM_PAGE_SELECT = q.page_sel;
  assign KEY_WRITE_ACCESS   = q.key_acc;
  assign PROT_VIOLATION     = q.viol;
  assign CMD_GO             = q.cmd_go;

  // Protected range start from the select fields
  always_comb begin
    if (q.prot[5:0] <= `NVMOPR_FPS_ALL) begin
      flash_start = 17'h00000;
    end else begin
      flash_start = `NVMOPR_FLASH_TOP -
        ({11'h000, `NVMOPR_FPS_NONE - q.prot[5:0]} * `NVMOPR_FLASH_STEP);
    end
    ee_size = `NVMOPR_EE_STEP << (2'h2 - q.prot[7:6]);
    if (CMD_EEPROM) begin
      hit_prot = q.prot[7:6] != `NVMOPR_EPS_NONE &&
                 CMD_ADDR >= `NVMOPR_EE_TOP - ee_size &&
                 CMD_ADDR < `NVMOPR_EE_TOP;
    end else begin
      hit_prot = {1'b0, CMD_ADDR} >= flash_start;
    end
  end

  // Read mux
  always_comb begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR[7:0])
      `NVMOPR_OFS_OPTION: rd_val = q.opt;
      `NVMOPR_OFS_CONFIG:
        rd_val = {1'b0, q.page_sel, q.key_acc, 5'h00};
      `NVMOPR_OFS_PROTECTION: rd_val = q.prot;
      `NVMOPR_OFS_STATUS: rd_val = {2'h0, q.viol, 5'h00};
      default: begin
        rd_val = 8'h00;
        rd_ok  = 1'b0;
      end
    endcase
    if (S_AXI_ARADDR[31:8] != 24'h000000) begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    d        = q;
    d.cmd_go = 1'b0;
    wr_fire  = q.aw_full & q.w_full & ~q.bvalid;
    wr_prot  = wr_fire & q.w_lane0 &
               q.aw_addr == `NVMOPR_OFS_PROTECTION;
    wr_dbg   = wr_prot & DEBUG_ACCESS;
    viol_clr = wr_fire & q.w_lane0 & q.aw_addr == `NVMOPR_OFS_STATUS &
               q.w_data[`NVMOPR_BIT_VIOL];
    key_hit  = CMD_VALID & q.key_acc &
               {CMD_ADDR[15:3], 3'h0} == `NVMOPR_KEY_BASE;
    key_fail = q.key_bad | (CMD_ADDR[2:0] != q.key_cnt) |
               (CMD_DATA != STORED_KEY[{q.key_cnt, 3'h0} +: 8]);
    key_take = key_hit & ~CMD_DEBUG &
               q.opt[`NVMOPR_BIT_KEY_EN] & secure;
    viol_set = 1'b0;
    case (q.fsm)
      NVMOPR_LOAD: begin
        d.opt  = NV_OPTION & `NVMOPR_OPT_MASK;
        d.prot = NV_PROTECTION;
        d.fsm  = NVMOPR_RUN;
      end
      NVMOPR_RUN: begin
        if (CMD_VALID && !key_hit) begin
          if (CMD_MASS ? prot_any : hit_prot) begin
            viol_set = 1'b1;
          end else begin
            d.cmd_go = 1'b1;
          end
        end
        if (key_take) begin
          d.key_cnt = q.key_cnt + 3'h1;
          d.key_bad = key_fail;
          if (q.key_cnt == `NVMOPR_KEY_LAST) begin
            d.key_bad = 1'b0;
            if (!key_fail) begin
              d.opt[1:0] = `NVMOPR_SEC_OPEN;
            end
          end
        end
        if (BLANK_OK) begin
          d.opt[1:0] = `NVMOPR_SEC_OPEN;
        end
        if (wr_fire && q.w_lane0 && q.aw_addr == `NVMOPR_OFS_CONFIG) begin
          d.page_sel = q.w_data[`NVMOPR_BIT_PAGE_SEL];
          d.key_acc  = q.w_data[`NVMOPR_BIT_KEY_ACC];
          if (!q.w_data[`NVMOPR_BIT_KEY_ACC]) begin
            d.key_cnt = 3'h0;
            d.key_bad = 1'b0;
          end
        end
        if (wr_dbg) begin
          d.prot = q.w_data;
        end else if (wr_prot) begin
          if (q.w_data[7:6] <= q.prot[7:6]) begin
            d.prot[7:6] = q.w_data[7:6];
          end
          if (q.w_data[5:0] <= q.prot[5:0]) begin
            d.prot[5:0] = q.w_data[5:0];
          end
        end
      end
      default: d.fsm = NVMOPR_LOAD;
    endcase
    d.viol = (q.viol & ~viol_clr) | viol_set;
    // Write channel: address and data in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      d.aw_full = 1'b1;
      d.aw_addr = S_AXI_AWADDR[31:8] == 24'h000000 ?
                  S_AXI_AWADDR[7:0] : 8'hff;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      d.w_full  = 1'b1;
      d.w_data  = S_AXI_WDATA[7:0];
      d.w_lane0 = S_AXI_WSTRB[0];
    end
    if (wr_fire) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      case (q.aw_addr)
        `NVMOPR_OFS_OPTION, `NVMOPR_OFS_CONFIG,
        `NVMOPR_OFS_PROTECTION, `NVMOPR_OFS_STATUS:
          d.bresp = `NVMOPR_RESP_OKAY;
        default: d.bresp = `NVMOPR_RESP_SLVERR;
      endcase
    end else if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_ok ? `NVMOPR_RESP_OKAY : `NVMOPR_RESP_SLVERR;
    end else if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q      <= '0;
      q.fsm  <= NVMOPR_LOAD;
      q.opt  <= `NVMOPR_RST_OPTION;
      q.prot <= `NVMOPR_RST_PROT;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_load;
    q.fsm == NVMOPR_LOAD && RST_N;
  endsequence
  sequence s_key_dbg;
    CMD_VALID && key_hit && CMD_DEBUG;
  endsequence

  opt_load_a: assert property (s_load |=>
    q.opt == ($past(NV_OPTION) & 8'he3) && q.fsm == NVMOPR_RUN)
    else $error("option not loaded from copy");
  prot_load_a: assert property (s_load |=>
    q.prot == $past(NV_PROTECTION))
    else $error("protection not loaded from copy");
  prot_grow_a: assert property (
    q.fsm == NVMOPR_RUN && !wr_dbg |=>
    q.prot[5:0] <= $past(q.prot[5:0]) && q.prot[7:6] <= $past(q.prot[7:6]))
    else $error("protection shrank without debug");
  dbg_prot_a: assert property (q.fsm == NVMOPR_RUN && wr_dbg |=>
    q.prot == $past(q.w_data) && S_AXI_BVALID)
    else $error("debug protection write lost");
  viol_set_a: assert property (viol_set |=>
    PROT_VIOLATION && !CMD_GO)
    else $error("violation not flagged");
  mass_ref_a: assert property (
    q.fsm == NVMOPR_RUN && CMD_VALID && CMD_MASS && !key_hit &&
    q.prot != 8'hff |=> !CMD_GO && PROT_VIOLATION)
    else $error("mass erase allowed while protected");
  key_gate_a: assert property (
    q.fsm == NVMOPR_RUN && !q.opt[7] && secure && !BLANK_OK |=> secure)
    else $error("unlocked with key disabled");
  key_dbg_a: assert property (
    q.fsm == NVMOPR_RUN && !wr_fire && !BLANK_OK ##0 s_key_dbg |=>
    $stable(q.key_cnt) && $stable(q.opt))
    else $error("debug key write counted");
  blank_a: assert property (q.fsm == NVMOPR_RUN && BLANK_OK |=>
    !SECURE [*1] ##0 q.opt[1:0] == 2'h2)
    else $error("blank check did not unsecure");
  viol_clr_a: assert property (viol_clr && !viol_set |=>
    !PROT_VIOLATION)
    else $error("violation flag not cleared");
  viol_hold_a: assert property (PROT_VIOLATION && !viol_clr |=>
    PROT_VIOLATION)
    else $error("violation flag dropped");
endmodule

// [bench/nvmopr_fw_model.sv]
// Firmware and debug side: nonvolatile copies and the NVM write path
// Assumes the bench resets the block after every reprogram call
module nvmopr_fw_model (
  input  wire logic        mclk,
  input  wire logic        cmd_go,
  output logic [7:0]       nv_option,
  output logic [7:0]       nv_protection,
  output logic [63:0]      stored_key,
  output logic             cmd_valid,
  output logic [15:0]      cmd_addr,
  output logic [7:0]       cmd_data,
  output logic             cmd_eeprom,
  output logic             cmd_mass,
  output logic             cmd_debug
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    nv_option = 8'h00;
    nv_protection = 8'hff;
    stored_key = 64'h0123456789abcdef;
    {cmd_valid, cmd_addr, cmd_data} = 25'h0;
    {cmd_eeprom, cmd_mass, cmd_debug} = 3'h0;
  end
  // New copies are only seen after the next reset
  task automatic reprogram(input logic [7:0] o, input logic [7:0] p);
    nv_option <= o;
    nv_protection <= p;
  endtask
  // One write on the path; kind is {eeprom, mass, debug}
  task automatic issue(input logic [15:0] a, input logic [7:0] d,
                       input logic [2:0] kind, output logic go);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_data <= d;
    {cmd_eeprom, cmd_mass, cmd_debug} <= kind;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    #1;
    go = cmd_go;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench of the option and protection registers
// Assumes the design files and the firmware model are compiled first
`include "nvmopr_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_RREADY, DEBUG_ACCESS, BLANK_OK;
  logic        UNSECURE_SRC, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, SECURE, ACCESS_BLOCK, CMD_GO;
  logic        VECTOR_REDIRECT_DISABLE, EEPROM_SECTOR_MODE, PROT_VIOLATION;
  logic        EEPROM_PAGE_SELECT, KEY_WRITE_ACCESS, CMD_VALID, CMD_EEPROM;
  logic        CMD_MASS, CMD_DEBUG, g;
  logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [2:0]  S_AXI_AWPROT = 3'h0;
  logic [2:0]  S_AXI_ARPROT = 3'h0;
  logic [3:0]  S_AXI_WSTRB = 4'h1;
  logic [7:0]  NV_OPTION, NV_PROTECTION, CMD_DATA;
  logic [15:0] CMD_ADDR;
  logic [63:0] STORED_KEY;
  int          fails = 0;
  int          n_compared = 0;
  nvmopr_top i_nvmopr_top (.MCLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWPROT,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .DEBUG_ACCESS, .NV_OPTION, .NV_PROTECTION, .STORED_KEY,
    .BLANK_OK, .UNSECURE_SRC, .CMD_VALID, .CMD_ADDR, .CMD_DATA,
    .CMD_EEPROM, .CMD_MASS, .CMD_DEBUG, .SECURE, .ACCESS_BLOCK,
    .VECTOR_REDIRECT_DISABLE, .EEPROM_SECTOR_MODE, .EEPROM_PAGE_SELECT,
    .KEY_WRITE_ACCESS, .PROT_VIOLATION, .CMD_GO);
  nvmopr_fw_model i_nvmopr_fw_model (.mclk(MCLK), .cmd_go(CMD_GO),
    .nv_option(NV_OPTION), .nv_protection(NV_PROTECTION),
    .stored_key(STORED_KEY), .cmd_valid(CMD_VALID), .cmd_addr(CMD_ADDR),
    .cmd_data(CMD_DATA), .cmd_eeprom(CMD_EEPROM), .cmd_mass(CMD_MASS),
    .cmd_debug(CMD_DEBUG));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic dbg, output logic [1:0] r);
    logic done, ta, tw;
    done = 1'b0;
    @(posedge MCLK);
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    S_AXI_AWADDR <= {24'h0, a};
    S_AXI_WDATA <= {24'h0, d};
    DEBUG_ACCESS <= dbg;
    while (!done) begin
      @(negedge MCLK);
      ta = S_AXI_AWREADY;
      tw = S_AXI_WREADY;
      done = S_AXI_BVALID;
      r = S_AXI_BRESP;
      @(posedge MCLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    DEBUG_ACCESS <= 1'b0;
  endtask
  task automatic rd_is(input logic [7:0] a, input logic [31:0] e);
    logic done, ta;
    done = 1'b0;
    @(posedge MCLK);
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    S_AXI_ARADDR <= {24'h0, a};
    while (!done) begin
      @(negedge MCLK);
      ta = S_AXI_ARREADY;
      done = S_AXI_RVALID;
      resp = S_AXI_RRESP;
      if (done) check(S_AXI_RDATA, e);
      @(posedge MCLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
    i_nvmopr_fw_model.reprogram(o, p);
    RST_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge MCLK);
  endtask
  // Eight key bytes; pass 0 has one wrong byte, pass 1 comes from debug
  task automatic key_try(input int p);
    for (int k = 0; k < 8; k++) begin
      i_nvmopr_fw_model.issue(16'hffb0 + 16'(k),
        STORED_KEY[8*k +: 8] ^ ((p == 0 && k == 3) ? 8'h01 : 8'h00),
        (p == 1) ? 3'b001 : 3'b000, g);
      check(g, 1'b0);
    end
  endtask
  task automatic t_load();
    do_reset(8'hff, 8'hfe);
    rd_is(`NVMOPR_OFS_OPTION, 32'he3);
    axw(`NVMOPR_OFS_OPTION, 8'h02, 1'b0, resp);
    check(resp, `NVMOPR_RESP_OKAY);
    rd_is(`NVMOPR_OFS_OPTION, 32'he3);
    check({SECURE, VECTOR_REDIRECT_DISABLE, EEPROM_SECTOR_MODE}, 3'h7);
    rd_is(`NVMOPR_OFS_PROTECTION, 32'hfe);
    UNSECURE_SRC <= 1'b1;
    @(negedge MCLK);
    check(ACCESS_BLOCK, 1'b1);
    axw(8'h10, 8'h55, 1'b0, resp);
    check(resp, `NVMOPR_RESP_SLVERR);
    rd_is(8'h10, 32'h00);
    check(resp, `NVMOPR_RESP_SLVERR);
    axw(`NVMOPR_OFS_CONFIG, 8'hff, 1'b0, resp);
    rd_is(`NVMOPR_OFS_CONFIG, 32'h60);
    check({EEPROM_PAGE_SELECT, KEY_WRITE_ACCESS}, 2'b11);
    $display("load and config test done");
  endtask
  task automatic t_key();
    key_try(0);
    check(SECURE, 1'b1);
    key_try(1);
    check(SECURE, 1'b1);
    key_try(2);
    check({SECURE, ACCESS_BLOCK}, 2'b00);
    rd_is(`NVMOPR_OFS_OPTION, 32'he2);
    do_reset(8'h7f, 8'hff);
    i_nvmopr_fw_model.issue(16'hffb0, 8'h00, 3'b000, g);
    check(g, 1'b1);
    axw(`NVMOPR_OFS_CONFIG, 8'h20, 1'b0, resp);
    check(EEPROM_PAGE_SELECT, 1'b0);
    key_try(2);
    check(SECURE, 1'b1);
    @(posedge MCLK);
    BLANK_OK <= 1'b1;
    @(posedge MCLK);
    BLANK_OK <= 1'b0;
    #1;
    check(SECURE, 1'b0);
    $display("key test done");
  endtask
  task automatic t_prot();
    axw(`NVMOPR_OFS_PROTECTION, 8'hfe, 1'b0, resp);
    axw(`NVMOPR_OFS_PROTECTION, 8'hff, 1'b0, resp);
    rd_is(`NVMOPR_OFS_PROTECTION, 32'hfe);
    axw(`NVMOPR_OFS_PROTECTION, 8'hbf, 1'b0, resp);
    rd_is(`NVMOPR_OFS_PROTECTION, 32'hbe);
    i_nvmopr_fw_model.issue(16'hfa00, 8'h00, 3'b000, g);
    check({g, PROT_VIOLATION}, 2'b01);
    axw(`NVMOPR_OFS_STATUS, 8'h20, 1'b0, resp);
    rd_is(`NVMOPR_OFS_STATUS, 32'h00);
    i_nvmopr_fw_model.issue(16'hf9ff, 8'h00, 3'b000, g);
    check({g, PROT_VIOLATION}, 2'b10);
    i_nvmopr_fw_model.issue(16'h17ef, 8'h00, 3'b100, g);
    check({g, PROT_VIOLATION}, 2'b10);
    i_nvmopr_fw_model.issue(16'h17f0, 8'h00, 3'b100, g);
    check({g, PROT_VIOLATION}, 2'b01);
    axw(`NVMOPR_OFS_STATUS, 8'h20, 1'b0, resp);
    i_nvmopr_fw_model.issue(16'h0000, 8'h00, 3'b010, g);
    check({g, PROT_VIOLATION}, 2'b01);
    axw(`NVMOPR_OFS_PROTECTION, 8'hff, 1'b1, resp);
    rd_is(`NVMOPR_OFS_PROTECTION, 32'hff);
    axw(`NVMOPR_OFS_STATUS, 8'h20, 1'b0, resp);
    i_nvmopr_fw_model.issue(16'h0000, 8'h00, 3'b010, g);
    check({g, PROT_VIOLATION}, 2'b10);
    $display("protection test done");
  endtask
  initial begin
    {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h0;
    {S_AXI_ARVALID, S_AXI_RREADY, DEBUG_ACCESS, BLANK_OK} = 4'h0;
    {UNSECURE_SRC, S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = 97'h0;
    t_load();
    t_key();
    t_prot();
    close_out();
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule
